// [verilog/pcdcl_defines.vh]
// Purpose: Shared constants of the power-up default configuration loader.
// Assumes: Included by its bare name from the design files.
// Notes:   Offsets are byte addresses on the serial register link.
`ifndef PCDCL_DEFINES_VH
`define PCDCL_DEFINES_VH

`define PCDCL_NREG          13
`define PCDCL_LAST_IDX      4'hC
`define PCDCL_CFG_FIRST     8'hA0
`define PCDCL_CFG_LAST      8'hAC
`define PCDCL_OFS_SAFE      8'hA0
`define PCDCL_OFS_SERIAL    8'hA1
`define PCDCL_OFS_CTRL1     8'hA2
`define PCDCL_OFS_CTRL2     8'hA3
`define PCDCL_OFS_CTRL3     8'hA4
`define PCDCL_OFS_FREQ      8'hA5
`define PCDCL_OFS_RAMP      8'hA6
`define PCDCL_OFS_PWRBTN    8'hA7
`define PCDCL_OFS_WDSETUP   8'hA8
`define PCDCL_OFS_WDEXPIRE  8'hA9
`define PCDCL_OFS_WDCOUNT   8'hAA
`define PCDCL_OFS_FLTCNT    8'hAB
`define PCDCL_OFS_FLTTMR    8'hAC
`define PCDCL_OFS_PAGE      8'h00
`define PCDCL_OFS_FLAGS     8'h01
`define PCDCL_OFS_MODE      8'h02

`define PCDCL_HW_SAFE       8'h00
`define PCDCL_HW_SERIAL     8'h00
`define PCDCL_HW_CTRL1      8'h02
`define PCDCL_HW_CTRL2      8'h05
`define PCDCL_HW_CTRL3      8'h01
`define PCDCL_HW_FREQ       8'h00
`define PCDCL_HW_RAMP       8'h55
`define PCDCL_HW_PWRBTN     8'h00
`define PCDCL_HW_WDSETUP    8'h10
`define PCDCL_HW_WDEXPIRE   8'h07
`define PCDCL_HW_WDCOUNT    8'hAF
`define PCDCL_HW_FLTCNT     8'hFF
`define PCDCL_HW_FLTTMR     8'h0F

`define PCDCL_TRIAL_ADDR    7'h08
`define PCDCL_BASE_ADDR     7'h08
`define PCDCL_ADDR_LSB      0
`define PCDCL_SECURE_BIT    6
`define PCDCL_CRC_BIT       7
`define PCDCL_FLAG_TRIM     0
`define PCDCL_FLAG_FUSE     1
`define PCDCL_FLAG_STEST    2
`define PCDCL_MIRROR_PAGE   3'h1
`define PCDCL_PAGE_RESET    3'h0
`define PCDCL_MIRROR_RESET  8'h00

`endif

// [verilog/pcdcl_i2c_target.v]
// Purpose: Serial link target that moves bytes between the link and the register file.
// Assumes: The link clock is slow against clk and is sampled, never used as a clock.
// Notes:   Open-drain data: sda_out is always low and sda_oe pulls the line.
`include "pcdcl_defines.vh"
module pcdcl_i2c_target (
  input  wire       clk,
  input  wire       sys_rst,
  input  wire       clk_en,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire [6:0] own_addr,
  input  wire [7:0] tx_data,
  output wire       sda_out,
  output reg        sda_oe,
  output reg        rx_stb,
  output reg        rx_first,
  output reg  [7:0] rx_data,
  output reg        tx_done
);
  localparam S_IDLE = 7'b0000001;
  localparam S_ADDR = 7'b0000010;
  localparam S_AACK = 7'b0000100;
  localparam S_WR   = 7'b0001000;
  localparam S_WACK = 7'b0010000;
  localparam S_RD   = 7'b0100000;
  localparam S_RACK = 7'b1000000;

  reg [1:0] scl_s_r;
  reg [1:0] sda_s_r;
  reg       scl_d_r;
  reg       sda_d_r;
  reg [6:0] st_r;
  reg [2:0] cnt_r;
  reg [7:0] sh_r;
  reg       full_r;
  reg       read_r;
  reg       first_r;
  wire scl = scl_s_r[1];
  wire sda = sda_s_r[1];
  wire rise = scl & ~scl_d_r;
  wire fall = ~scl & scl_d_r;
  wire start = scl & scl_d_r & sda_d_r & ~sda;
  wire stop = scl & scl_d_r & ~sda_d_r & sda;

  assign sda_out = 1'b0;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      st_r <= S_IDLE;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      full_r <= 1'b0;
      read_r <= 1'b0;
      first_r <= 1'b0;
      sda_oe <= 1'b0;
      rx_stb <= 1'b0;
      rx_first <= 1'b0;
      rx_data <= 8'h00;
      tx_done <= 1'b0;
    end else if (clk_en) begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_d_r <= scl;
      sda_d_r <= sda;
      rx_stb <= 1'b0;
      tx_done <= 1'b0;
      if (start) begin
        st_r <= S_ADDR;
        cnt_r <= 3'h0;
        full_r <= 1'b0;
        sda_oe <= 1'b0;
      end else if (stop) begin
        st_r <= S_IDLE;
        sda_oe <= 1'b0;
      end else if (rise) begin
        if (st_r == S_ADDR || st_r == S_WR) begin
          sh_r <= {sh_r[6:0], sda};
          cnt_r <= cnt_r + 3'h1;
          full_r <= (cnt_r == 3'h7);
        end else if (st_r == S_RACK && sda) begin
          // A refused read byte ends the transfer until the next start.
          st_r <= S_IDLE;
        end
      end else if (fall) begin
        case (st_r)
          S_ADDR: begin
            if (full_r && sh_r[7:1] == own_addr) begin
              read_r <= sh_r[0];
              first_r <= 1'b1;
              sda_oe <= 1'b1;
              st_r <= S_AACK;
            end else if (full_r) begin
              st_r <= S_IDLE;
            end
          end
          S_WR: begin
            if (full_r) begin
              rx_stb <= 1'b1;
              rx_first <= first_r;
              rx_data <= sh_r;
              first_r <= 1'b0;
              sda_oe <= 1'b1;
              st_r <= S_WACK;
            end
          end
          S_RD: begin
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'h7) begin
              sda_oe <= 1'b0;
              tx_done <= 1'b1;
              st_r <= S_RACK;
            end else begin
              sda_oe <= ~sh_r[6];
              sh_r <= {sh_r[6:0], 1'b0};
            end
          end
          S_AACK, S_WACK, S_RACK: begin
            full_r <= 1'b0;
            cnt_r <= 3'h0;
            if (read_r) begin
              sh_r <= tx_data;
              sda_oe <= ~tx_data[7];
              st_r <= S_RD;
            end else begin
              sda_oe <= 1'b0;
              st_r <= S_WR;
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end
endmodule // pcdcl_i2c_target

// [verilog/pcdcl_loader.v]
// Purpose: Selects, loads and guards the power-up default configuration.
// Assumes: Fuse array answers in the same cycle; flag and sequencer inputs share clk.
// Notes:   Mode is latched at each load or power-up, page access follows the live pin.
// How it works
// [RULE_01] Trial mode: plain link, no checksum, no secure write.
// [RULE_02] Trial mode answers on fixed address 0x08.
// [RULE_03] Trial mode disables all watchdog supervision.
// [RULE_04] Page 1 reaches mirrors while trial pin high; the gate also needs the source pin low.
// [RULE_05] Trial pin low refuses extended pages.
// [RULE_06] Mirrors preload from fuses, host-writable in trial.
// [RULE_07] System holds trial pin low for full features.
// [RULE_08] Supply undervoltage resets mirrors; redo trial setup.
// [RULE_09] Fuse burning only in trial and quiescent off.
// [RULE_10] Hardwired source copies fixed defaults on reload.
// [RULE_11] Trim still read; trim failure sets flag.
// [RULE_12] Hardwired source plus trial pin means debug.
// [RULE_13] Debug forces quiescent off; self-test result recorded.
// [RULE_14] Hardwired source keeps fuse-load flag at zero.
// [RULE_15] Any failure flag blocks power-up until cleared.
// [RULE_16] Flags writable only in debug mode.
// [RULE_17] Default expiry limit selects count of eight.
// [RULE_18] Default counter: 1024 ms window, count 16.
// [RULE_19] Default fault counters all ones, sixteen each.
// [RULE_20] Default timers: one minute, fault timer off.
// [RULE_21] Default frequency 2.5 MHz, sync in/out off.
// [RULE_22] Default watchdog: rising-edge soft reset, timer off.
// [RULE_23] Grounded source pin takes defaults from mirrors.
// [RULE_24] Fuse source: fuses to mirrors, then mirrors onward.
// [RULE_25] Pins sampled at load or power-up, then held; the page gate and the burn window follow the live pins.
`include "pcdcl_defines.vh"
module pcdcl_loader (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         clk_en,
  input  wire         trial_mode_pin,
  input  wire         config_source_pin,
  input  wire         input_supply_ok,
  input  wire         power_up_event,
  input  wire         scl_in,
  input  wire         sda_in,
  output wire         sda_out,
  output wire         sda_oe,
  output wire [3:0]   fuse_addr,
  input  wire [7:0]   fuse_data,
  input  wire         trim_fail,
  input  wire         fuse_fail,
  input  wire         selftest_done,
  input  wire         selftest_fail,
  input  wire         quiescent_off_state,
  input  wire         reload_req,
  output wire [103:0] func_cfg,
  output wire [6:0]   i2c_own_addr,
  output reg          crc_en,
  output reg          secure_wr_en,
  output reg  [7:0]   wdog_cfg,
  output reg          wdog_active,
  output wire         trial_config_mode,
  output wire         debug_mode,
  output wire         force_qoff,
  output reg          power_up_go,
  output reg          fuse_prog_allow,
  output wire         load_busy
);
  localparam LD_IDLE = 3'b001;
  localparam LD_FUSE = 3'b010;
  localparam LD_COPY = 3'b100;

  reg  [7:0] mir_r [0:`PCDCL_NREG-1];
  reg  [7:0] fnc_r [0:`PCDCL_NREG-1];
  reg  [3:0] sa_r;
  reg  [3:0] sb_r;
  reg        uv_d_r;
  reg        pu_d_r;
  reg  [2:0] ld_r;
  reg  [3:0] idx_r;
  reg        trial_r;
  reg        hw_r;
  reg  [2:0] page_r;
  reg  [2:0] flag_r;
  reg  [2:0] flag_nxt;
  reg  [7:0] ptr_r;
  reg  [7:0] tx_data;
  wire       rx_stb;
  wire       rx_first;
  wire [7:0] rx_data;
  wire       tx_done;
  integer    i;
  genvar     g;

  wire trial_s = sb_r[0];
  wire src_s = sb_r[1];
  wire uv_s = sb_r[2];
  wire pu_s = sb_r[3];
  wire uv_rise = uv_s & ~uv_d_r;
  wire pu_rise = pu_s & ~pu_d_r;
  wire wr_stb = rx_stb & ~rx_first;
  wire ext_page = (page_r != `PCDCL_PAGE_RESET);
  // The page gate and the burn window follow the live pins, not the latched mode.
  wire trial_fuse_s = trial_s & ~src_s;
  // [RULE_04] Mirror page gate
  // [RULE_05] Live pin gate
  wire mir_ok = trial_fuse_s & (page_r == `PCDCL_MIRROR_PAGE);
  wire ld_start = uv_rise | (reload_req & uv_s);

  function is_cfg;
    input [7:0] a;
    begin
      is_cfg = (a >= `PCDCL_CFG_FIRST) && (a <= `PCDCL_CFG_LAST);
    end
  endfunction

  function [3:0] cfg_idx;
    input [7:0] a;
    reg   [7:0] d;
    begin
      d = a - `PCDCL_CFG_FIRST;
      cfg_idx = d[3:0];
    end
  endfunction

  function last_row;
    input [3:0] n;
    begin
      last_row = (n == `PCDCL_LAST_IDX);
    end
  endfunction

  // The fixed set is kept as constants so it cannot drift with fuse contents.
  function [7:0] hw_default;
    input [3:0] n;
    begin
      case (n)
        4'h0: hw_default = `PCDCL_HW_SAFE;
        4'h1: hw_default = `PCDCL_HW_SERIAL;
        4'h2: hw_default = `PCDCL_HW_CTRL1;
        4'h3: hw_default = `PCDCL_HW_CTRL2;
        4'h4: hw_default = `PCDCL_HW_CTRL3;
        // [RULE_21] Frequency default
        4'h5: hw_default = `PCDCL_HW_FREQ;
        4'h6: hw_default = `PCDCL_HW_RAMP;
        4'h7: hw_default = `PCDCL_HW_PWRBTN;
        // [RULE_22] Watchdog setup default
        4'h8: hw_default = `PCDCL_HW_WDSETUP;
        // [RULE_17] Expiry limit default
        4'h9: hw_default = `PCDCL_HW_WDEXPIRE;
        // [RULE_18] Counter default
        4'hA: hw_default = `PCDCL_HW_WDCOUNT;
        // [RULE_19] Fault counters default
        4'hB: hw_default = `PCDCL_HW_FLTCNT;
        // [RULE_20] Fault timers default
        4'hC: hw_default = `PCDCL_HW_FLTTMR;
        default: hw_default = 8'h00;
      endcase
    end
  endfunction

  pcdcl_i2c_target u_link (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .own_addr (i2c_own_addr),
    .tx_data  (tx_data),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .rx_stb   (rx_stb),
    .rx_first (rx_first),
    .rx_data  (rx_data),
    .tx_done  (tx_done)
  );

  generate
    for (g = 0; g < `PCDCL_NREG; g = g + 1) begin : g_out
      assign func_cfg[g*8 +: 8] = fnc_r[g];
    end
  endgenerate

  assign fuse_addr = idx_r;
  assign load_busy = ~ld_r[0];
  // [RULE_12] Hardwired source gives debug
  assign trial_config_mode = trial_r & ~hw_r;
  assign debug_mode = trial_r & hw_r;
  // [RULE_13] Low-power-off default ignored
  assign force_qoff = debug_mode;
  // [RULE_02] Fixed address in trial
  assign i2c_own_addr = trial_config_mode ? `PCDCL_TRIAL_ADDR
                      : (`PCDCL_BASE_ADDR | {4'h0, fnc_r[1][`PCDCL_ADDR_LSB +: 3]});

  // Pins and the supply level come from outside the clock domain.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sa_r <= 4'h0;
      sb_r <= 4'h0;
      uv_d_r <= 1'b0;
      pu_d_r <= 1'b0;
    end else if (clk_en) begin
      sa_r <= {power_up_event, input_supply_ok, config_source_pin, trial_mode_pin};
      sb_r <= sa_r;
      uv_d_r <= uv_s;
      pu_d_r <= pu_s;
    end
  end

  always @* begin
    tx_data = 8'h00;
    if (ptr_r == `PCDCL_OFS_PAGE)
      tx_data = {5'h00, page_r};
    else if (ext_page && is_cfg(ptr_r) && mir_ok)
      tx_data = mir_r[cfg_idx(ptr_r)];
    else if (!ext_page && ptr_r == `PCDCL_OFS_FLAGS)
      tx_data = {5'h00, flag_r};
    else if (!ext_page && ptr_r == `PCDCL_OFS_MODE)
      tx_data = {5'h00, load_busy, debug_mode, trial_config_mode};
    else if (!ext_page && is_cfg(ptr_r))
      tx_data = fnc_r[cfg_idx(ptr_r)];
  end

  // Load sequencer, mode latch and the two register sets.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ld_r <= LD_IDLE;
      idx_r <= 4'h0;
      trial_r <= 1'b0;
      hw_r <= 1'b0;
      for (i = 0; i < `PCDCL_NREG; i = i + 1) begin
        mir_r[i] <= `PCDCL_MIRROR_RESET;
        fnc_r[i] <= `PCDCL_MIRROR_RESET;
      end
    end else if (clk_en) begin
      // [RULE_25] Mode sampled and held
      if (ld_start || pu_rise) begin
        trial_r <= trial_s;
        hw_r <= src_s;
      end
      // [RULE_06] Host edits mirrors
      if (wr_stb && ext_page && mir_ok && is_cfg(ptr_r) && ld_r[0])
        mir_r[cfg_idx(ptr_r)] <= rx_data;
      case (ld_r)
        LD_IDLE: begin
          idx_r <= 4'h0;
          // [RULE_24] Fuse stage on supply rise
          if (uv_rise && !src_s)
            ld_r <= LD_FUSE;
          else if (ld_start)
            ld_r <= LD_COPY;
        end
        LD_FUSE: begin
          mir_r[idx_r] <= fuse_data;
          idx_r <= idx_r + 4'h1;
          if (last_row(idx_r)) begin
            idx_r <= 4'h0;
            ld_r <= LD_COPY;
          end
        end
        LD_COPY: begin
          // [RULE_10] Hardwired set copied
          // [RULE_23] Mirrors feed functional set
          fnc_r[idx_r] <= hw_r ? hw_default(idx_r) : mir_r[idx_r];
          idx_r <= idx_r + 4'h1;
          if (last_row(idx_r))
            ld_r <= LD_IDLE;
        end
        default: ld_r <= LD_IDLE;
      endcase
      // [RULE_08] Mirrors lost below threshold
      if (!uv_s) begin
        ld_r <= LD_IDLE;
        for (i = 0; i < `PCDCL_NREG; i = i + 1)
          mir_r[i] <= `PCDCL_MIRROR_RESET;
      end
    end
  end

  // Hardware sets always beat a host write in the same cycle.
  always @* begin
    flag_nxt = flag_r;
    // [RULE_16] Debug-only flag writes
    if (wr_stb && !ext_page && ptr_r == `PCDCL_OFS_FLAGS && debug_mode)
      flag_nxt = rx_data[2:0];
    if (ld_r[2] && last_row(idx_r)) begin
      // [RULE_11] Trim failure flagged
      if (trim_fail)
        flag_nxt[`PCDCL_FLAG_TRIM] = 1'b1;
      if (fuse_fail && !hw_r)
        flag_nxt[`PCDCL_FLAG_FUSE] = 1'b1;
    end
    // [RULE_14] Fuse flag zero when hardwired
    if (hw_r)
      flag_nxt[`PCDCL_FLAG_FUSE] = 1'b0;
    // [RULE_13] Self-test outcome recorded
    if (selftest_done)
      flag_nxt[`PCDCL_FLAG_STEST] = selftest_fail;
  end

  // Register pointer and page select.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_r <= 8'h00;
      page_r <= `PCDCL_PAGE_RESET;
    end else if (clk_en) begin
      if (rx_stb && rx_first)
        ptr_r <= rx_data;
      else if (wr_stb || tx_done)
        ptr_r <= ptr_r + 8'h01;
      if (wr_stb && ptr_r == `PCDCL_OFS_PAGE)
        page_r <= rx_data[2:0];
    end
  end

  // Failure flags and the power-up gate.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 3'h0;
      power_up_go <= 1'b0;
    end else if (clk_en) begin
      flag_r <= flag_nxt;
      // A power-up edge that lands during a load is dropped, not queued.
      // [RULE_15] Flags block power-up
      power_up_go <= pu_rise && (flag_r == 3'h0) && uv_s && ld_r[0];
    end
  end

  // Link options and watchdog set-up are registered so a mode change never glitches them.
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      crc_en <= 1'b0;
      secure_wr_en <= 1'b0;
      wdog_cfg <= 8'h00;
      wdog_active <= 1'b0;
      fuse_prog_allow <= 1'b0;
    end else if (clk_en) begin
      // [RULE_01] Standard link form in trial
      crc_en <= fnc_r[1][`PCDCL_CRC_BIT] & ~trial_config_mode;
      secure_wr_en <= fnc_r[1][`PCDCL_SECURE_BIT] & ~trial_config_mode;
      // [RULE_03] Watchdog off in trial
      wdog_cfg <= trial_config_mode ? 8'h00 : fnc_r[8];
      wdog_active <= ~trial_config_mode;
      // [RULE_09] Fuse burning window
      fuse_prog_allow <= trial_fuse_s & quiescent_off_state;
    end
  end
endmodule // pcdcl_loader

// [bench/pcdcl_loader_chk.sv]
// Purpose: Port assertions for the configuration loader.
// Assumes: One clock domain; clk_en stays high while checked.
// Notes:   Mode outputs are latched, so registered outputs may lag them one cycle.
module pcdcl_loader_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       quiescent_off_state,
  input wire logic [6:0] i2c_own_addr,
  input wire logic       crc_en,
  input wire logic       secure_wr_en,
  input wire logic [7:0] wdog_cfg,
  input wire logic       wdog_active,
  input wire logic       trial_config_mode,
  input wire logic       debug_mode,
  input wire logic       force_qoff,
  input wire logic       power_up_go,
  input wire logic       fuse_prog_allow,
  input wire logic       load_busy
);
  timeunit 1ns;
  timeprecision 10ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [5:0] busy_len_r;
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      busy_len_r <= 6'h00;
    else
      busy_len_r <= load_busy ? busy_len_r + 6'h01 : 6'h00;
  trial_addr_a: assert property (trial_config_mode |-> i2c_own_addr == 7'h08)
    else $error("own address not fixed in trial mode");
  trial_link_a: assert property (trial_config_mode && $past(trial_config_mode)
    |-> !crc_en && !secure_wr_en) else $error("checksum or secure write in trial mode");
  trial_wdog_a: assert property (trial_config_mode && $past(trial_config_mode)
    |-> !wdog_active && wdog_cfg == 8'h00) else $error("watchdog active in trial mode");
  mode_excl_a: assert property (!(trial_config_mode && debug_mode))
    else $error("trial and debug mode together");
  debug_qoff_a: assert property (force_qoff == debug_mode)
    else $error("quiescent off not tied to debug mode");
  prog_gate_a: assert property (fuse_prog_allow |-> $past(quiescent_off_state))
    else $error("fuse programming allowed outside quiescent off");
  go_pulse_a: assert property (power_up_go |=> !power_up_go)
    else $error("power-up accept longer than one cycle");
  go_idle_a: assert property (power_up_go |-> !$past(load_busy))
    else $error("power-up accepted during a load");
  load_len_a: assert property ($fell(load_busy) |-> busy_len_r == 6'h0D || busy_len_r == 6'h1A)
    else $error("load length not 13 or 26 cycles");
endmodule // pcdcl_loader_chk
bind pcdcl_loader pcdcl_loader_chk i_pcdcl_loader_chk (.clk(clk), .sys_rst(sys_rst),
  .quiescent_off_state(quiescent_off_state), .i2c_own_addr(i2c_own_addr), .crc_en(crc_en),
  .secure_wr_en(secure_wr_en), .wdog_cfg(wdog_cfg), .wdog_active(wdog_active),
  .trial_config_mode(trial_config_mode), .debug_mode(debug_mode), .force_qoff(force_qoff),
  .power_up_go(power_up_go), .fuse_prog_allow(fuse_prog_allow), .load_busy(load_busy));

// [bench/pcdcl_host.sv]
// Purpose: Host controller model on the serial register link.
// Assumes: Data line has a pull-up; the device only pulls it low.
// Notes:   Link clock stands high between frames; reads are single bytes ended by a NACK.
module pcdcl_host (
  input  wire logic sda_oe,
  output logic      scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 10ps;
  logic       pull_r = 1'b0;
  logic       nak_seen = 1'b0;
  logic       n;
  logic [7:0] junk;
  initial scl = 1'b1;
  assign sda = ~(pull_r | sda_oe);
  task lv(input logic c, d);
    scl <= c;
    pull_r <= ~d;
    #31.25;
  endtask
  // Data only moves while the link clock is low, so no false START or STOP.
  task bitx(input logic b, output logic r);
    lv(1'b0, b);
    lv(1'b1, b);
    r = sda;
    lv(1'b1, b);
    lv(1'b0, b);
  endtask
  task start;
    lv(1'b1, 1'b1);
    lv(1'b1, 1'b0);
    lv(1'b0, 1'b0);
  endtask
  task stop;
    lv(1'b0, 1'b0);
    lv(1'b1, 1'b0);
    lv(1'b1, 1'b1);
  endtask
  task xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
      bitx(b[i], r[i]);
    bitx(1'b1, n);
    if (n !== 1'b0)
      nak_seen = 1'b1;
  endtask
  task wr(input logic [7:0] p, d);
    start;
    xfer(8'h10, junk);
    xfer(p, junk);
    xfer(d, junk);
    stop;
  endtask
  task rd(input logic [7:0] p, output logic [7:0] r);
    start;
    xfer(8'h10, junk);
    xfer(p, junk);
    stop;
    start;
    xfer(8'h11, junk);
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, r[i]);
    bitx(1'b1, n);
    stop;
  endtask
endmodule // pcdcl_host

// [bench/test_pcdcl_loader.sv]
// Purpose: Self-checking bench for the configuration loader.
// Assumes: clk_en held high; fuse rows answer in the same cycle.
// Notes:   Fuse row n holds {~n, n}, so every row differs from its neighbours.
module test_pcdcl_loader;
  timeunit 1ns;
  timeprecision 10ps;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         pin_t = 1'b0, pin_s = 1'b0, vok = 1'b0, pu = 1'b0, rld = 1'b0;
  logic         tf = 1'b0, ff = 1'b0, std = 1'b0, stf = 1'b0, qoff = 1'b0;
  wire          scl, sda, sda_oe, t_mode, d_mode, qo, go, pa, busy, crc, sec, wda;
  wire  [3:0]   fa;
  wire  [6:0]   own;
  wire  [7:0]   wdc;
  wire  [103:0] fc;
  int           bad_count = 0, compares = 0, gos = 0;
  logic [7:0]   v;
  logic [7:0]   hw [13] = '{8'h00, 8'h00, 8'h02, 8'h05, 8'h01, 8'h00, 8'h55, 8'h00, 8'h10, 8'h07, 8'hAF,
                            8'hFF, 8'h0F};
  always #2 clk = ~clk;
  always @(posedge clk)
    if (go === 1'b1)
      gos++;
  pcdcl_loader i_pcdcl_loader (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1), .trial_mode_pin(pin_t),
    .config_source_pin(pin_s), .input_supply_ok(vok), .power_up_event(pu), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .fuse_addr(fa), .fuse_data({~fa, fa}), .trim_fail(tf), .fuse_fail(ff),
    .selftest_done(std), .selftest_fail(stf), .quiescent_off_state(qoff), .reload_req(rld), .func_cfg(fc),
    .i2c_own_addr(own), .crc_en(crc), .secure_wr_en(sec), .wdog_cfg(wdc), .wdog_active(wda),
    .trial_config_mode(t_mode), .debug_mode(d_mode), .force_qoff(qo), .power_up_go(go),
    .fuse_prog_allow(pa), .load_busy(busy));
  pcdcl_host i_pcdcl_host (.sda_oe(sda_oe), .scl(scl), .sda(sda));
  function automatic logic [7:0] fv(input int i);
    return {~i[3:0], i[3:0]};
  endfunction
  task chk(input logic [103:0] got, exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task load(input logic s, t);
    pin_s <= s;
    pin_t <= t;
    vok <= 1'b0;
    cyc(6);
    vok <= 1'b1;
    cyc(8);
    for (int k = 0; k < 40 && busy !== 1'b0; k++)
      cyc(1);
    chk(busy, 1'b0);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // The whole run needs about 70 us; the limit leaves wide margin.
  initial begin
    #380000;
    bad_count++;
    print_verdict;
  end
  initial begin
    cyc(20);
    sys_rst <= 1'b0;
    cyc(2);
    chk(fc, 104'h0);
    chk({own, sda_oe}, {7'h08, 1'b0});
    $display("test reset done");
    for (int r = 0; r < 26; r++) begin
      if (r % 13 == 0)
        load(r >= 13, 1'b0);
      chk(fc[8*(r%13) +: 8], r < 13 ? fv(r) : hw[r-13]);
      if (r == 12)
        chk({own, crc, sec, wdc, wda}, {7'h09, 2'b11, fv(8), 1'b1});
    end
    $display("test default rows done");
    load(1'b0, 1'b1);
    chk({t_mode, d_mode, own, crc, sec, wdc, wda}, {2'b10, 7'h08, 2'b00, 8'h00, 1'b0});
    i_pcdcl_host.wr(8'h00, 8'h01);
    i_pcdcl_host.wr(8'hA0, 8'hC3);
    i_pcdcl_host.rd(8'hA1, v);
    chk(v, fv(1));
    i_pcdcl_host.rd(8'hA0, v);
    chk(v, 8'hC3);
    chk(i_pcdcl_host.nak_seen, 1'b0);
    rld <= 1'b1;
    cyc(1);
    rld <= 1'b0;
    cyc(20);
    chk(fc[7:0], 8'hC3);
    pin_t <= 1'b0;
    cyc(6);
    chk(t_mode, 1'b1);
    i_pcdcl_host.rd(8'hA0, v);
    chk(v, 8'h00);
    pin_t <= 1'b1;
    qoff <= 1'b1;
    cyc(6);
    chk(pa, 1'b1);
    qoff <= 1'b0;
    cyc(4);
    chk(pa, 1'b0);
    $display("test trial mode done");
    vok <= 1'b0;
    cyc(6);
    i_pcdcl_host.wr(8'h00, 8'h01);
    i_pcdcl_host.rd(8'hA0, v);
    chk(v, 8'h00);
    load(1'b0, 1'b1);
    i_pcdcl_host.rd(8'hA0, v);
    chk({v, fc[7:0]}, {fv(0), fv(0)});
    $display("test supply loss done");
    i_pcdcl_host.wr(8'h00, 8'h00);
    tf <= 1'b1;
    ff <= 1'b1;
    load(1'b1, 1'b0);
    tf <= 1'b0;
    ff <= 1'b0;
    i_pcdcl_host.wr(8'h01, 8'h00);
    i_pcdcl_host.rd(8'h01, v);
    chk(v, 8'h01);
    pu <= 1'b1;
    cyc(8);
    pu <= 1'b0;
    cyc(8);
    chk(gos, 0);
    $display("test failure flags done");
    qoff <= 1'b1;
    load(1'b1, 1'b1);
    chk({d_mode, t_mode, qo, pa}, 4'b1010);
    i_pcdcl_host.rd(8'h02, v);
    chk(v, 8'h02);
    stf <= 1'b1;
    std <= 1'b1;
    cyc(1);
    std <= 1'b0;
    cyc(4);
    i_pcdcl_host.rd(8'h01, v);
    chk(v, 8'h05);
    i_pcdcl_host.wr(8'h01, 8'h00);
    stf <= 1'b0;
    std <= 1'b1;
    cyc(1);
    std <= 1'b0;
    cyc(4);
    i_pcdcl_host.rd(8'h01, v);
    chk(v, 8'h00);
    pu <= 1'b1;
    cyc(8);
    pu <= 1'b0;
    cyc(8);
    chk(gos, 1);
    $display("test debug mode done");
    print_verdict;
  end
endmodule // test_pcdcl_loader
